// ---- hdl/stk_core.sv ----
/*
 * 2048 x 8 static memory with a bcd calendar clock in the top eight bytes.
 * assumes strobes, address and data arrive asynchronously from a host and
 * that data_bus is resolved outside from the enable output.
 */
module stk_core
   import stk_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   // host strobes
   input  wire logic                      sel_n_in,
   input  wire logic                      gate_n_in,
   input  wire logic                      wr_n_in,
   input  wire logic                      power_fail_in,
   // address and data
   input  wire logic [stk_pkg::STK_ADDR_W-1:0] addr_lines_in,
   input  wire logic [stk_pkg::STK_DATA_W-1:0] data_bus_in,
   output logic      [stk_pkg::STK_DATA_W-1:0] data_bus_out,
   output logic                           data_bus_oe_out,
   // status
   output logic                           write_mode_out
);
   import stk_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      logic [3:0]            sel_s;
      logic [3:0]            gate_s;
      logic [3:0]            wr_s;
      logic [1:0]            pf_s;
      logic [21:0]           addr_s;
      logic [15:0]           din_s;
      logic [10:0]           addr_q;
      logic [2:0]            aa_cnt;
      logic [2:0]            ce_cnt;
      logic [2:0]            oe_cnt;
      logic [2:0]            hold_cnt;
      logic [7:0]            dout;
      logic                  oe;
      logic                  wmode;
      stk_mode_t             mode;
      logic [23:0]           tick;
      logic [7:0]            c_sec;
      logic [7:0]            c_min;
      logic [7:0]            c_hour;
      logic [7:0]            c_day;
      logic [7:0]            c_date;
      logic [7:0]            c_mon;
      logic [7:0]            c_year;
      logic                  whalt_q;
   } stk_state_t;

   stk_state_t                 state_reg;
   stk_state_t                 state_next;
   logic [STK_DATA_W-1:0]      mem [0:STK_DEPTH-1];
   logic [STK_DATA_W-1:0]      tk_reg [0:7];

   function automatic logic [7:0] stk_bcd_inc(input logic [7:0] v);
      if (v[3:0] == STK_NIB_9)
         return (v & 8'hF0) + STK_NIB_STEP;
      return v + STK_ONE;
   endfunction

   function automatic logic [7:0] stk_mdays(input logic [7:0] m,
                                            input logic [7:0] y);
      logic leap;
      leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00) : (y[1:0] == 2'b10);
      if (m == STK_BCD_02)
         return leap ? STK_BCD_29 : STK_BCD_28;
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
         return STK_BCD_30;
      return STK_BCD_31;
   endfunction

   // ************************************************************
   // synchronised views
   // ************************************************************
   logic        sel_a;
   logic        gate_a;
   logic        wr_a;
   logic        pf_a;
   logic        wr_act;
   logic        wr_act_d;
   logic        wr_end;
   logic [10:0] addr_a;
   logic [7:0]  din_a;
   logic        is_tk;
   logic        sec_pulse;
   logic        do_copy;
   logic        load;
   logic [7:0]  ctrl;

   always_comb
   begin
      sel_a    = ~state_reg.sel_s[1];
      gate_a   = ~state_reg.gate_s[1];
      wr_a     = ~state_reg.wr_s[1];
      pf_a     = state_reg.pf_s[1];
      addr_a   = state_reg.addr_s[21:11];
      din_a    = state_reg.din_s[15:8];
      // write mode while both strobes low; ends at the earlier rise
      wr_act   = sel_a & wr_a & ~pf_a;
      wr_act_d = state_reg.wmode;
      // a supply fail in mid-write drops the write instead of storing it
      wr_end   = wr_act_d & ~wr_act & ~pf_a;
      is_tk    = (state_reg.addr_q[10:3] == STK_TK_TOP);
      ctrl     = tk_reg[0];
      sec_pulse = (state_reg.tick == 24'(STK_SEC_CYC - 1));
      // copy suspended by either halt bit
      do_copy  = sec_pulse & ~ctrl[STK_B_RHALT] & ~ctrl[STK_B_WHALT];
      load     = state_reg.whalt_q & ~ctrl[STK_B_WHALT];
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      state_next = state_reg;
      state_next.sel_s  = {state_reg.sel_s[2:0], sel_n_in};
      state_next.gate_s = {state_reg.gate_s[2:0], gate_n_in};
      state_next.wr_s   = {state_reg.wr_s[2:0], wr_n_in};
      state_next.pf_s   = {state_reg.pf_s[0], power_fail_in};
      state_next.addr_s = {state_reg.addr_s[10:0], addr_lines_in};
      state_next.din_s  = {state_reg.din_s[7:0], data_bus_in};
      state_next.addr_q = addr_a;
      state_next.whalt_q = ctrl[STK_B_WHALT];
      // access timers restart on address or strobe change
      if (addr_a != state_reg.addr_q)
      begin
         state_next.aa_cnt   = '0;
         state_next.hold_cnt = '0;
      end
      else if (state_reg.aa_cnt != 3'(STK_AA_CYC))
         state_next.aa_cnt = state_reg.aa_cnt + 3'd1;
      if (state_reg.hold_cnt != 3'(STK_HOLD_CYC))
         state_next.hold_cnt = state_reg.hold_cnt + 3'd1;
      if (!sel_a)
         state_next.ce_cnt = '0;
      else if (state_reg.ce_cnt != 3'(STK_AA_CYC))
         state_next.ce_cnt = state_reg.ce_cnt + 3'd1;
      if (!gate_a)
         state_next.oe_cnt = '0;
      else if (state_reg.oe_cnt != 3'(STK_GATE_CYC))
         state_next.oe_cnt = state_reg.oe_cnt + 3'd1;
      // mode decode
      if (pf_a || !sel_a)
         state_next.mode = STK_IDLE;
      else if (wr_a)
         state_next.mode = STK_WRITE;
      else
         state_next.mode = STK_READ;
      state_next.wmode = (state_next.mode == STK_WRITE);
      // drive only in read mode with the gate low
      state_next.oe = gate_a & (state_next.mode == STK_READ);
      if (state_reg.aa_cnt == 3'(STK_AA_CYC) &&
          state_reg.ce_cnt == 3'(STK_AA_CYC) &&
          state_reg.oe_cnt == 3'(STK_GATE_CYC))
         state_next.dout = is_tk ? tk_reg[state_reg.addr_q[2:0]]
                                 : mem[state_reg.addr_q];
      else if (state_reg.hold_cnt == 3'(STK_HOLD_CYC))
         state_next.dout = STK_DATA_X;
      // counters
      state_next.tick = sec_pulse ? '0 : state_reg.tick + 24'd1;
      if (load)
      begin
         state_next.c_sec  = tk_reg[1];
         state_next.c_min  = tk_reg[2];
         state_next.c_hour = tk_reg[3];
         state_next.c_day  = tk_reg[4];
         state_next.c_date = tk_reg[5];
         state_next.c_mon  = tk_reg[6];
         state_next.c_year = tk_reg[7];
         state_next.tick   = '0;
      end
      else if (sec_pulse)
      begin
         state_next.c_sec = stk_bcd_inc(state_reg.c_sec);
         if (state_reg.c_sec == STK_BCD_59)
         begin
            state_next.c_sec = STK_BCD_00;
            state_next.c_min = stk_bcd_inc(state_reg.c_min);
            if (state_reg.c_min == STK_BCD_59)
            begin
               state_next.c_min  = STK_BCD_00;
               state_next.c_hour = stk_bcd_inc(state_reg.c_hour);
               if (state_reg.c_hour == STK_BCD_23)
               begin
                  state_next.c_hour = STK_BCD_00;
                  state_next.c_day  = (state_reg.c_day == STK_BCD_07) ?
                     STK_BCD_01 : stk_bcd_inc(state_reg.c_day);
                  state_next.c_date = stk_bcd_inc(state_reg.c_date);
                  if (state_reg.c_date ==
                      stk_mdays(state_reg.c_mon, state_reg.c_year))
                  begin
                     state_next.c_date = STK_BCD_01;
                     state_next.c_mon  = stk_bcd_inc(state_reg.c_mon);
                     if (state_reg.c_mon == STK_BCD_12)
                     begin
                        state_next.c_mon  = STK_BCD_01;
                        state_next.c_year =
                           (state_reg.c_year == STK_BCD_99) ?
                           STK_BCD_00 : stk_bcd_inc(state_reg.c_year);
                     end
                  end
               end
            end
         end
      end
   end

   // ************************************************************
   // registers and storage
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg        <= '0;
         state_reg.sel_s  <= 4'hF;
         state_reg.gate_s <= 4'hF;
         state_reg.wr_s   <= 4'hF;
         state_reg.mode   <= STK_IDLE;
         state_reg.c_day  <= STK_BCD_01;
         state_reg.c_date <= STK_BCD_01;
         state_reg.c_mon  <= STK_BCD_01;
      end
      else
         state_reg <= state_next;
   end

   // clock bytes are separate cells with a second write port
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < 8; i++)
            tk_reg[i] <= STK_BCD_00;
      end
      else
      begin
         if (do_copy)
         begin
            tk_reg[1] <= state_reg.c_sec;
            tk_reg[2] <= state_reg.c_min;
            tk_reg[3] <= state_reg.c_hour;
            tk_reg[4] <= state_reg.c_day;
            tk_reg[5] <= state_reg.c_date;
            tk_reg[6] <= state_reg.c_mon;
            tk_reg[7] <= state_reg.c_year;
         end
         // host write wins over the copy in the same cycle
         if (wr_end && is_tk)
            tk_reg[state_reg.addr_q[2:0]] <= din_a;
      end
   end

   // main array, one-cycle write at the end of each write
   always_ff @(posedge clk_in)
   begin
      if (wr_end && !is_tk)
         mem[state_reg.addr_q] <= din_a;
   end

   assign data_bus_out    = state_reg.dout;
   assign data_bus_oe_out = state_reg.oe;
   assign write_mode_out  = state_reg.wmode;
endmodule

// ---- hdl/stk_pkg.sv ----
/*
 * constants for the byte-wide static memory with clock registers in the top
 * eight bytes. assumes a 10 MHz system clock and strobes from an outside
 * host that are synchronised inside the core.
 */
package stk_pkg;
   // ************************************************************
   // geometry
   // ************************************************************
   localparam int          STK_ADDR_W   = 11;
   localparam int          STK_DATA_W   = 8;
   localparam int          STK_DEPTH    = 2048;
   localparam logic [10:0] STK_A_CTRL   = 11'h07F8;
   localparam logic [10:0] STK_A_SEC    = 11'h07F9;
   localparam logic [10:0] STK_A_MIN    = 11'h07FA;
   localparam logic [10:0] STK_A_HOUR   = 11'h07FB;
   localparam logic [10:0] STK_A_DAY    = 11'h07FC;
   localparam logic [10:0] STK_A_DATE   = 11'h07FD;
   localparam logic [10:0] STK_A_MONTH  = 11'h07FE;
   localparam logic [10:0] STK_A_YEAR   = 11'h07FF;
   localparam logic [7:0]  STK_TK_TOP   = 8'hFF;
   // control byte bits
   localparam int          STK_B_WHALT  = 7;
   localparam int          STK_B_RHALT  = 6;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int          STK_CLK_NS   = 100;
   localparam int          STK_AA_NS    = 120;
   localparam int          STK_GATE_NS  = 75;
   localparam int          STK_HOLD_NS  = 15;
   localparam int          STK_AA_CYC   =
      (STK_AA_NS + STK_CLK_NS - 1) / STK_CLK_NS;
   localparam int          STK_GATE_CYC =
      (STK_GATE_NS + STK_CLK_NS - 1) / STK_CLK_NS;
   localparam int          STK_HOLD_CYC =
      (STK_HOLD_NS / STK_CLK_NS) < 1 ? 1 : STK_HOLD_NS / STK_CLK_NS;
   localparam int          STK_SEC_CYC  = 10_000_000;
   // ************************************************************
   // bcd limits and resets
   // ************************************************************
   localparam logic [7:0]  STK_BCD_59   = 8'h59;
   localparam logic [7:0]  STK_BCD_23   = 8'h23;
   localparam logic [7:0]  STK_BCD_99   = 8'h99;
   localparam logic [7:0]  STK_BCD_07   = 8'h07;
   localparam logic [7:0]  STK_BCD_12   = 8'h12;
   localparam logic [7:0]  STK_BCD_01   = 8'h01;
   localparam logic [7:0]  STK_BCD_00   = 8'h00;
   localparam logic [7:0]  STK_BCD_02   = 8'h02;
   localparam logic [7:0]  STK_BCD_28   = 8'h28;
   localparam logic [7:0]  STK_BCD_29   = 8'h29;
   localparam logic [7:0]  STK_BCD_30   = 8'h30;
   localparam logic [7:0]  STK_BCD_31   = 8'h31;
   localparam logic [3:0]  STK_NIB_9    = 4'h9;
   localparam logic [7:0]  STK_NIB_STEP = 8'h10;
   localparam logic [7:0]  STK_ONE      = 8'h01;
   localparam logic [7:0]  STK_DATA_X   = 8'hFF;

   typedef enum logic [2:0]
   {
      STK_IDLE  = 3'b001,
      STK_READ  = 3'b010,
      STK_WRITE = 3'b100
   } stk_mode_t;
endpackage

// ---- test/stk_core_bench.sv ----
/* self-checking bench for stk_core.
   assumes the host model in stk_host and no copy within the run. */
module stk_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import stk_pkg::*;
   logic                  clk_in   = 1'b0;
   logic                  rst_n_in = 1'b0;
   logic                  pf       = 1'b0;
   logic                  sel_n, gate_n, wr_n, oe, wm, o;
   logic [STK_ADDR_W-1:0] addr;
   logic [STK_DATA_W-1:0] din, dout, d;
   int                    miscompares = 0;
   int                    compares    = 0;
   logic [10:0] ta[3] = '{11'h000, 11'h155, 11'h7F7};
   logic [7:0]  td[3] = '{8'h5A, 8'hC3, 8'h0F};
   // control, seconds, minutes, hour, day, date, month, year
   logic [7:0]  ck[8] = '{8'h80, 8'h59, 8'h59, 8'h23,
                          8'h07, 8'h29, 8'h02, 8'h96};
`define STK_CHK(nm, ex, sn) \
   begin \
      compares++; \
      if ((sn) !== (ex)) \
      begin \
         miscompares++; \
         $display("Error %s expected %h seen %h", nm, ex, sn); \
      end \
   end
   always #50 clk_in = ~clk_in;
   stk_core i_stk_core (.clk_in, .rst_n_in, .sel_n_in(sel_n),
      .gate_n_in(gate_n), .wr_n_in(wr_n), .power_fail_in(pf),
      .addr_lines_in(addr), .data_bus_in(din), .data_bus_out(dout),
      .data_bus_oe_out(oe), .write_mode_out(wm));
   stk_host i_stk_host (.clk_in, .dout_in(dout), .oe_in(oe),
      .sel_n_out(sel_n), .gate_n_out(gate_n), .wr_n_out(wr_n),
      .addr_out(addr), .bus_out(din));
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #2_000_000;
      miscompares++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      i_stk_host.rd(STK_A_YEAR, d, o);
      `STK_CHK("year reset", 8'h00, d)
      i_stk_host.idle();
      for (int i = 0; i < 3; i++)
      begin
         i_stk_host.wr(ta[i], ~td[i], 1'b1, 1'b0);
         i_stk_host.wr(ta[i], td[i], 1'b0, i[0]);
      end
      for (int i = 0; i < 3; i++)
      begin
         i_stk_host.rd(ta[i], d, o);
         `STK_CHK("mem data", td[i], d)
         `STK_CHK("mem drive", 1'b1, o)
      end
      i_stk_host.idle();
      for (int i = 0; i < 8; i++)
         i_stk_host.wr(STK_A_CTRL + 11'(i), ck[i], 1'b1, 1'b0);
      for (int i = 7; i >= 0; i--)
      begin
         i_stk_host.rd(STK_A_CTRL + 11'(i), d, o);
         `STK_CHK("clock byte", ck[i], d)
      end
      i_stk_host.idle();
      @(posedge clk_in);
      pf <= 1'b1;
      i_stk_host.wr(ta[1], 8'h3C, 1'b1, 1'b0);
      i_stk_host.rd(ta[1], d, o);
      `STK_CHK("fail drive", 1'b0, o)
      i_stk_host.idle();
      pf <= 1'b0;
      i_stk_host.idle();
      i_stk_host.rd(ta[1], d, o);
      `STK_CHK("fail write", td[1], d)
      i_stk_host.idle();
      summarize();
   end
endmodule

// ---- test/stk_host.sv ----
/* host model driving the strobes and the shared data bus.
   assumes the core's registered drive enable and read data. */
module stk_host (
   input  wire logic                            clk_in,
   input  wire logic [stk_pkg::STK_DATA_W-1:0] dout_in,
   input  wire logic                            oe_in,
   output logic                                 sel_n_out,
   output logic                                 gate_n_out,
   output logic                                 wr_n_out,
   output logic      [stk_pkg::STK_ADDR_W-1:0] addr_out,
   output logic      [stk_pkg::STK_DATA_W-1:0] bus_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import stk_pkg::*;
   logic                  drv  = 1'b0;
   logic [STK_DATA_W-1:0] wdat = 8'h00;
   logic [STK_DATA_W-1:0] pat  = 8'h00;
   initial
   begin
      sel_n_out = 1'b1;
      gate_n_out = 1'b1;
      wr_n_out = 1'b1;
      addr_out = '0;
   end
   // a floating bus shows a pattern that moves every cycle
   assign bus_out = oe_in ? dout_in : (drv ? wdat : pat);
   always @(posedge clk_in)
      pat <= pat + 8'h01;
   task automatic idle();
      @(posedge clk_in);
      sel_n_out <= 1'b1;
      gate_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      drv <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
   task automatic wr(input logic [STK_ADDR_W-1:0] a,
                     input logic [STK_DATA_W-1:0] d,
                     input logic g, input logic by_sel);
      @(posedge clk_in);
      addr_out <= a;
      wdat <= d;
      drv <= 1'b1;
      gate_n_out <= g;
      sel_n_out <= 1'b0;
      wr_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      if (by_sel)
         sel_n_out <= 1'b1;
      else
         wr_n_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      idle();
   endtask
   // leaves the strobes low so a following call ripples
   task automatic rd(input logic [STK_ADDR_W-1:0] a,
                     output logic [STK_DATA_W-1:0] d, output logic o);
      @(posedge clk_in);
      addr_out <= a;
      sel_n_out <= 1'b0;
      gate_n_out <= 1'b0;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      d = dout_in;
      o = oe_in;
   endtask
endmodule

// ---- test/stk_props.sv ----
/* port checker for stk_core.
   assumes host strobes are held four cycles or more. */
module stk_props (
   input wire logic                            clk_in,
   input wire logic                            rst_n_in,
   input wire logic                            sel_n_in,
   input wire logic                            gate_n_in,
   input wire logic                            wr_n_in,
   input wire logic                            power_fail_in,
   input wire logic [stk_pkg::STK_ADDR_W-1:0] addr_lines_in,
   input wire logic [stk_pkg::STK_DATA_W-1:0] data_bus_in,
   input wire logic [stk_pkg::STK_DATA_W-1:0] data_bus_out,
   input wire logic                            data_bus_oe_out,
   input wire logic                            write_mode_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import stk_pkg::*;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ****************************************
   // request sequences
   // ****************************************
   sequence s_rd_req;
      !sel_n_in && !gate_n_in && wr_n_in && !power_fail_in;
   endsequence
   sequence s_wr_req;
      !sel_n_in && !wr_n_in && !power_fail_in;
   endsequence
   a_read_drives: assert property (s_rd_req [*4] |-> data_bus_oe_out)
      else $error("bus not driven in read");
   a_desel_float: assert property (sel_n_in [*4] |-> !data_bus_oe_out)
      else $error("bus driven while deselected");
   a_gate_float: assert property (gate_n_in [*4] |-> !data_bus_oe_out)
      else $error("bus driven with gate high");
   a_write_float: assert property (!wr_n_in [*4] |-> !data_bus_oe_out)
      else $error("bus driven during write");
   a_fail_ignores: assert property (power_fail_in [*4] |->
      !data_bus_oe_out && !write_mode_out)
      else $error("strobes obeyed during supply fail");
   a_write_mode: assert property (s_wr_req [*4] |-> write_mode_out)
      else $error("write mode missing");
   a_write_ends: assert property ((sel_n_in || wr_n_in) [*4] |->
      !write_mode_out)
      else $error("write mode after strobe rise");
   a_read_stable: assert property (
      (!sel_n_in && !gate_n_in && wr_n_in && !power_fail_in &&
      $stable(addr_lines_in)) [*8] |-> $stable(data_bus_out))
      else $error("read data moved at fixed address");
endmodule

bind stk_core stk_props i_stk_props (
   .clk_in,
   .rst_n_in,
   .sel_n_in,
   .gate_n_in,
   .wr_n_in,
   .power_fail_in,
   .addr_lines_in,
   .data_bus_in,
   .data_bus_out,
   .data_bus_oe_out,
   .write_mode_out
);
